// [psc_host_model.sv]
/* host side model: sleep pin, request bit and interrupt pin.
   knobs come from the bench; pins change only at sys_clk edges. */
`timescale 1ns/1ns
module psc_host_model (
    // clock
    input wire logic sys_clk,
    // knobs
    input wire logic use_pin,
    input wire logic want_sleep,
    input wire logic irq,
    input wire logic pol_inv,
    // pins and bits toward the block
    output psc_pkg::psc_sleep_s sleep_in
);
    always_ff @(posedge sys_clk) begin
        sleep_in.sleep_pol_inv <= pol_inv;
        sleep_in.int_pol_high <= pol_inv;
        // pin style sets the bit once; bit style parks the pin active
        sleep_in.sleep_request_bit <= use_pin | want_sleep;
        sleep_in.sleep_pin <= pol_inv ^ (use_pin & ~want_sleep);
        sleep_in.interrupt_output_pin <= ~(irq ^ pol_inv);
    end
endmodule : psc_host_model

// [psc_pkg.sv]
/*
 * Package for the power sequence controller: resource indices, slot
 * assignments and boot defaults, timing counts and the carrier structs.
 * Assumes a 100 MHz system clock; the slow slot tick is derived from it.
 */
package psc_pkg;

    // clock and slot timing
    localparam int CLK_HZ = 100_000_000;
    localparam int SLOT_SHORT_US = 500;
    localparam int SLOT_LONG_US = 2000;
    localparam int SLOT_SHORT_CYC = SLOT_SHORT_US * (CLK_HZ / 1_000_000);
    localparam int SLOT_LONG_CYC = SLOT_LONG_US * (CLK_HZ / 1_000_000);
    localparam int NUM_SLOTS = 15;

    // resource vector: bit positions
    localparam int NUM_RES = 19;
    localparam int RES_CORE_A = 0;
    localparam int RES_CORE_B = 1;
    localparam int RES_IO = 2;
    localparam int RES_EXT_FET = 3;
    localparam int RES_REG1 = 4;
    localparam int RES_REG2 = 5;
    localparam int RES_REG3 = 6;
    localparam int RES_REG4 = 7;
    localparam int RES_REG5 = 8;
    localparam int RES_REG6 = 9;
    localparam int RES_REG7 = 10;
    localparam int RES_REG8 = 11;
    localparam int RES_CLK_OUT = 12;
    localparam int RES_SYS_RST = 13;
    localparam int RES_EN_GP0 = 14;
    localparam int RES_EN_GP2 = 15;
    localparam int RES_EN_GP6 = 16;
    localparam int RES_EN_GP7 = 17;
    localparam int RES_SPARE = 18;

    // slot code 0 means not assigned; 1..15 are slots
    localparam logic [3:0] SLOT_OFF = 4'h0;
    localparam logic [NUM_RES*4-1:0] FIXED_SLOTS = {
        4'h0, // spare
        4'h5, 4'h6, 4'h0, 4'h1, // enable pins 7,6,2,0
        4'ha, 4'h5, // system reset, clock out
        4'h7, 4'h5, 4'h0, 4'h0, 4'h2, 4'h0, 4'h7, 4'h0, // regulators 8..1
        4'h0, 4'h4, 4'h6, 4'h3 // ext fet, io, core b, core a
    };

    // boot voltage codes (16 entries): 0.6,0.7,0.8,0.85,...,1.35,1.4,1.5
    // index 10 in the code list above; 9 would be 1.15 V
    localparam logic [3:0] CORE_A_BOOT_CODE = 4'ha; // 1.2 V
    localparam logic [3:0] CORE_B_BOOT_CODE = 4'hf; // 1.5 V
    localparam logic [3:0] EXT_FET_BOOT_CODE = 4'h0;
    localparam logic [1:0] IO_BOOT_CODE = 2'h1; // 1.8 V
    localparam logic GAIN_X1 = 1'b0;

    // boot mode strap
    typedef enum logic [2:0] {
        PSC_BOOT_FIXED = 3'h1,
        PSC_BOOT_EEPROM = 3'h2,
        PSC_BOOT_TEST = 3'h4
    } psc_boot_e;

    typedef enum logic [5:0] {
        PSC_ST_OFF = 6'h01,
        PSC_ST_SEQ_ON = 6'h02,
        PSC_ST_ACTIVE = 6'h04,
        PSC_ST_SLEEP = 6'h08,
        PSC_ST_SEQ_OFF = 6'h10,
        PSC_ST_STRAP = 6'h20
    } psc_state_e;

    // sleep entry inputs
    typedef struct packed {
        logic sleep_pin;
        logic sleep_pol_inv;
        logic sleep_request_bit;
        logic interrupt_output_pin;
        logic int_pol_high;
    } psc_sleep_s;

    // reset sources
    typedef struct packed {
        logic por_n;
        logic long_press_reset_bit;
        logic off_and_reset_bit;
        logic hard_reset_input;
    } psc_rst_s;

    // boot configuration applied to the converters
    typedef struct packed {
        logic [3:0] core_a_code;
        logic [3:0] core_b_code;
        logic [3:0] ext_fet_code;
        logic [1:0] io_code;
        logic core_a_gain;
        logic [1:0] core_b_gain;
        logic core_a_pulse_skip_bit;
        logic core_b_pulse_skip_bit;
        logic io_pulse_skip_bit;
    } psc_boot_cfg_s;

endpackage : psc_pkg

// [psc_power_sequence_controller.sv]
/*
 * Power sequence controller: power state machine (off, sequenced on,
 * active, sleep, sequenced or simultaneous off), three reset scopes,
 * boot strap sampling and fixed boot defaults.
 * Assumes all inputs synchronous to sys_clk; eeprom slot table and
 * voltage codes arrive as static ports; analog parts live elsewhere.
 */
// Operation
// - sleep needs the sleep pin active; active low unless polarity inverted
// - sleep needs the sleep-request bit set to one
// - no sleep while an unmasked interrupt is pending
// - software drives sleep by the request bit or by the pin
// - power-on reset clears all digital logic
// - general reset from long-press, off-and-reset or hard-reset input
// - turnoff reset reinitialises power handling while off
// - off-to-active runs fifteen slots enabling assigned resources
// - each slot lasts 0.5 ms or 2 ms
// - unassigned resources stay off; their voltage field stays writable
// - power-off disables everything at once by default
// - reverse-off bit powers off in reverse slot order
// - core and ext-fet boot voltages use sixteen codes
// - regulator boot levels in 50 mV or 100 mV steps
// - strap: floating test, zero fixed, one eeprom boot
// - strap pad disabled once sampled
// - fixed boot: core a 1.2 V, gain x1, slot 3
// - fixed boot: core b 1.5 V, gain x1, slot 6
// - fixed boot: io converter 1.8 V, slot 4
// - fixed boot: pulse skip on for both cores and io
// - core b gain x1 or x3; core a gain x1 or x2
// - fixed boot: ext-fet controller unassigned and off
// - slot-duration bit zero gives 0.5 ms, one gives 2 ms
// - in sleep, selected supplies go to low-power mode
`timescale 1ns/1ns
module psc_power_sequence_controller #(
    parameter int SLOT_SHORT = psc_pkg::SLOT_SHORT_CYC,
    parameter int SLOT_LONG = psc_pkg::SLOT_LONG_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // reset sources
    input wire psc_pkg::psc_rst_s rst_src,
    // power control
    input wire logic power_on_request,
    input wire logic reverse_poweroff_bit,
    input wire logic slot_duration_bit,
    // sleep control
    input wire psc_pkg::psc_sleep_s sleep_in,
    input wire logic [psc_pkg::NUM_RES-1:0] sleep_lp_select,
    // boot strap pad: level and floating detect
    input wire logic boot_mode_strap,
    input wire logic boot_strap_floating,
    // eeprom boot configuration
    input wire logic [psc_pkg::NUM_RES*4-1:0] eeprom_slots,
    input wire psc_pkg::psc_boot_cfg_s eeprom_cfg,
    // software voltage writes, honoured while a rail is off
    input wire logic sel_wr,
    input wire logic [1:0] sel_wr_target,
    input wire logic [3:0] sel_wr_code,
    // outputs
    output logic [psc_pkg::NUM_RES-1:0] res_enable,
    output logic [psc_pkg::NUM_RES-1:0] res_low_power,
    output logic low_freq_clock_output_en,
    output logic system_reset_output,
    output psc_pkg::psc_boot_cfg_s boot_cfg,
    output psc_pkg::psc_boot_e boot_mode,
    output logic strap_pad_enable,
    output psc_pkg::psc_state_e pwr_state,
    output logic general_reset,
    output logic turnoff_reset
);

    // slot counter is 24 bits wide; refuse lengths it cannot hold
    if (SLOT_SHORT < 1 || SLOT_LONG < SLOT_SHORT || SLOT_LONG > 2**24 - 1) begin : g_bad_slot
        $error("slot lengths out of range");
    end

    typedef struct packed {
        psc_pkg::psc_state_e state;
        psc_pkg::psc_boot_e boot;
        logic strap_done;
        logic [23:0] tick_cnt;
        logic [3:0] slot;
        logic [psc_pkg::NUM_RES-1:0] en;
        logic [psc_pkg::NUM_RES-1:0] lp;
        psc_pkg::psc_boot_cfg_s cfg;
        logic [psc_pkg::NUM_RES*4-1:0] slots;
    } psc_state_s;

    psc_state_s st_reg;
    psc_state_s st_next;

    logic sleep_pin_active;
    logic irq_pending;
    logic sleep_ok;
    logic gen_rst;
    logic [23:0] slot_len;
    logic tick;

    assign sleep_pin_active = sleep_in.sleep_pin ^ ~sleep_in.sleep_pol_inv;
    assign irq_pending = sleep_in.interrupt_output_pin ^ ~sleep_in.int_pol_high;
    assign sleep_ok = sleep_pin_active && sleep_in.sleep_request_bit
        && !irq_pending;
    assign gen_rst = rst_src.long_press_reset_bit || rst_src.off_and_reset_bit
        || rst_src.hard_reset_input;
    // slot-duration bit picks the slot length
    assign slot_len = slot_duration_bit ? 24'(SLOT_LONG) : 24'(SLOT_SHORT);
    assign tick = (st_reg.tick_cnt == slot_len - 24'h1);

    // resources whose slot equals s
    function automatic logic [psc_pkg::NUM_RES-1:0] in_slot(
        input logic [psc_pkg::NUM_RES*4-1:0] tbl,
        input logic [3:0] s
    );
        logic [psc_pkg::NUM_RES-1:0] m;
        m = '0;
        for (int i = 0; i < psc_pkg::NUM_RES; i++) begin
            m[i] = (tbl[i*4 +: 4] == s) && (s != psc_pkg::SLOT_OFF);
        end
        return m;
    endfunction : in_slot

    always_comb begin
        st_next = st_reg;
        st_next.tick_cnt = tick ? 24'h0 : st_reg.tick_cnt + 24'h1;
        case (st_reg.state)
            psc_pkg::PSC_ST_STRAP: begin
                // strap sampled once, pad then switched off
                if (boot_strap_floating) begin
                    st_next.boot = psc_pkg::PSC_BOOT_TEST;
                end else if (boot_mode_strap) begin
                    st_next.boot = psc_pkg::PSC_BOOT_EEPROM;
                end else begin
                    st_next.boot = psc_pkg::PSC_BOOT_FIXED;
                end
                st_next.strap_done = 1'b1;
                if (boot_strap_floating || boot_mode_strap) begin
                    st_next.slots = eeprom_slots;
                    st_next.cfg = eeprom_cfg;
                end else begin
                    st_next.slots = psc_pkg::FIXED_SLOTS;
                    st_next.cfg.core_a_code = psc_pkg::CORE_A_BOOT_CODE;
                    st_next.cfg.core_b_code = psc_pkg::CORE_B_BOOT_CODE;
                    st_next.cfg.ext_fet_code = psc_pkg::EXT_FET_BOOT_CODE;
                    st_next.cfg.io_code = psc_pkg::IO_BOOT_CODE;
                    st_next.cfg.core_a_gain = psc_pkg::GAIN_X1;
                    st_next.cfg.core_b_gain = {1'b0, psc_pkg::GAIN_X1};
                    st_next.cfg.core_a_pulse_skip_bit = 1'b1;
                    st_next.cfg.core_b_pulse_skip_bit = 1'b1;
                    st_next.cfg.io_pulse_skip_bit = 1'b1;
                end
                st_next.state = psc_pkg::PSC_ST_OFF;
            end
            psc_pkg::PSC_ST_OFF: begin
                st_next.en = '0;
                st_next.lp = '0;
                if (power_on_request && !gen_rst) begin
                    st_next.state = psc_pkg::PSC_ST_SEQ_ON;
                    st_next.slot = 4'h1;
                    st_next.tick_cnt = 24'h0;
                    st_next.en = in_slot(st_reg.slots, 4'h1);
                end
            end
            psc_pkg::PSC_ST_SEQ_ON: begin
                if (!power_on_request) begin
                    st_next.state = psc_pkg::PSC_ST_SEQ_OFF;
                    st_next.slot = psc_pkg::NUM_SLOTS[3:0];
                    st_next.tick_cnt = 24'h0;
                end else if (tick) begin
                    if (st_reg.slot == psc_pkg::NUM_SLOTS[3:0]) begin
                        st_next.state = psc_pkg::PSC_ST_ACTIVE;
                    end else begin
                        st_next.slot = st_reg.slot + 4'h1;
                        st_next.en = st_reg.en | in_slot(st_reg.slots, st_reg.slot + 4'h1);
                    end
                end
            end
            psc_pkg::PSC_ST_ACTIVE: begin
                st_next.lp = '0;
                if (!power_on_request) begin
                    st_next.state = psc_pkg::PSC_ST_SEQ_OFF;
                    st_next.slot = psc_pkg::NUM_SLOTS[3:0];
                    st_next.tick_cnt = 24'h0;
                end else if (sleep_ok) begin
                    st_next.state = psc_pkg::PSC_ST_SLEEP;
                    st_next.lp = sleep_lp_select & st_reg.en;
                end
            end
            psc_pkg::PSC_ST_SLEEP: begin
                if (!power_on_request) begin
                    st_next.state = psc_pkg::PSC_ST_SEQ_OFF;
                    st_next.lp = '0;
                    st_next.slot = psc_pkg::NUM_SLOTS[3:0];
                    st_next.tick_cnt = 24'h0;
                end else if (!sleep_ok) begin
                    st_next.state = psc_pkg::PSC_ST_ACTIVE;
                    st_next.lp = '0;
                end
            end
            psc_pkg::PSC_ST_SEQ_OFF: begin
                if (!reverse_poweroff_bit) begin
                    st_next.en = '0;
                    st_next.state = psc_pkg::PSC_ST_OFF;
                end else begin
                    // last slot's resources drop first
                    st_next.en = st_reg.en & ~in_slot(st_reg.slots, st_reg.slot);
                    if (tick) begin
                        if (st_reg.slot == 4'h1) begin
                            st_next.state = psc_pkg::PSC_ST_OFF;
                        end else begin
                            st_next.slot = st_reg.slot - 4'h1;
                        end
                    end
                end
            end
            default: begin
                st_next.state = psc_pkg::PSC_ST_OFF;
            end
        endcase
        // voltage codes writable only while the rail is off
        if (sel_wr) begin
            case (sel_wr_target)
                2'h0: if (!st_reg.en[psc_pkg::RES_CORE_A]) st_next.cfg.core_a_code = sel_wr_code;
                2'h1: if (!st_reg.en[psc_pkg::RES_CORE_B]) st_next.cfg.core_b_code = sel_wr_code;
                2'h2: if (!st_reg.en[psc_pkg::RES_EXT_FET]) st_next.cfg.ext_fet_code = sel_wr_code;
                default: if (!st_reg.en[psc_pkg::RES_IO]) st_next.cfg.io_code = sel_wr_code[1:0];
            endcase
        end
        // general reset drops power handling but keeps strap and boot config
        if (gen_rst) begin
            st_next.state = psc_pkg::PSC_ST_OFF;
            st_next.en = '0;
            st_next.lp = '0;
            st_next.slot = 4'h0;
            st_next.tick_cnt = 24'h0;
        end
    end

    // full reset from srst or a supply-loss por
    always_ff @(posedge sys_clk) begin
        if (srst || !rst_src.por_n) begin
            st_reg <= '{state: psc_pkg::PSC_ST_STRAP, boot: psc_pkg::PSC_BOOT_FIXED,
                default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign res_enable = st_reg.en;
    assign res_low_power = st_reg.lp;
    assign low_freq_clock_output_en = st_reg.en[psc_pkg::RES_CLK_OUT];
    assign system_reset_output = st_reg.en[psc_pkg::RES_SYS_RST];
    assign boot_cfg = st_reg.cfg;
    assign boot_mode = st_reg.boot;
    assign strap_pad_enable = !st_reg.strap_done;
    assign pwr_state = st_reg.state;
    assign general_reset = gen_rst;
    // turnoff scope: power handling held clear while off
    assign turnoff_reset = (st_reg.state == psc_pkg::PSC_ST_OFF);

endmodule : psc_power_sequence_controller

// [psc_seq_checker.sv]
/* assertions on the sequencer ports.
   bound into every psc_power_sequence_controller instance. */
`timescale 1ns/1ns
module psc_seq_checker #(
    parameter int SLOT_SHORT = 5,
    parameter int SLOT_LONG = 20
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // controls
    input wire psc_pkg::psc_rst_s rst_src,
    input wire logic power_on_request,
    input wire logic reverse_poweroff_bit,
    input wire logic slot_duration_bit,
    input wire psc_pkg::psc_sleep_s sleep_in,
    // status
    input wire logic [psc_pkg::NUM_RES-1:0] res_enable,
    input wire psc_pkg::psc_boot_e boot_mode,
    input wire logic strap_pad_enable,
    input wire psc_pkg::psc_state_e pwr_state,
    input wire logic general_reset,
    input wire logic turnoff_reset
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic [15:0] on_cnt_reg;
    logic act;
    logic go;
    logic irq;
    assign act = pwr_state == psc_pkg::PSC_ST_ACTIVE;
    assign go = power_on_request && !general_reset && rst_src.por_n;
    assign irq = sleep_in.interrupt_output_pin == sleep_in.int_pol_high;
    // cycles spent in the power-on sequence so far
    always_ff @(posedge sys_clk) begin
        on_cnt_reg <= (pwr_state == psc_pkg::PSC_ST_SEQ_ON) ? on_cnt_reg + 16'h1 : 16'h0;
    end
    sequence on_done;
        pwr_state == psc_pkg::PSC_ST_SEQ_ON ##1 act;
    endsequence
    a_sleep_pin_gate: assert property (act && sleep_in.sleep_pin != sleep_in.sleep_pol_inv
        |=> pwr_state != psc_pkg::PSC_ST_SLEEP) else $error("sleep with pin idle");
    a_sleep_bit_gate: assert property (act && !sleep_in.sleep_request_bit
        |=> pwr_state != psc_pkg::PSC_ST_SLEEP) else $error("sleep without request");
    a_sleep_irq_gate: assert property (act && irq
        |=> pwr_state != psc_pkg::PSC_ST_SLEEP) else $error("sleep with irq pending");
    a_sleep_irq_exit: assert property (pwr_state == psc_pkg::PSC_ST_SLEEP && go && irq
        |=> act) else $error("sleep held with irq");
    a_seq_start: assert property (pwr_state == psc_pkg::PSC_ST_OFF && go
        |=> pwr_state == psc_pkg::PSC_ST_SEQ_ON) else $error("power-on not taken");
    a_slot_length: assert property (on_done |-> ($past(on_cnt_reg) + 16'h1) ==
        16'(15 * ($past(slot_duration_bit) ? SLOT_LONG : SLOT_SHORT))) else $error("bad seq length");
    a_fast_off: assert property (pwr_state == psc_pkg::PSC_ST_SEQ_OFF && !reverse_poweroff_bit
        && rst_src.por_n |=> res_enable == '0) else $error("enables left on");
    a_genrst_src: assert property (general_reset == (|rst_src[2:0]))
        else $error("general reset source mismatch");
    a_genrst_off: assert property (general_reset && rst_src.por_n
        |=> pwr_state == psc_pkg::PSC_ST_OFF && res_enable == '0) else $error("general reset ignored");
    a_full_reset: assert property (!rst_src.por_n
        |=> pwr_state == psc_pkg::PSC_ST_STRAP && res_enable == '0) else $error("por ignored");
    a_strap_pad_off: assert property (pwr_state != psc_pkg::PSC_ST_STRAP |-> !strap_pad_enable)
        else $error("strap pad still on");
    a_turnoff_scope: assert property (pwr_state == psc_pkg::PSC_ST_OFF |-> turnoff_reset)
        else $error("turnoff reset low in off");
    a_fet_stays_off: assert property (boot_mode == psc_pkg::PSC_BOOT_FIXED
        |-> !res_enable[psc_pkg::RES_EXT_FET]) else $error("ext fet enabled");
endmodule : psc_seq_checker

bind psc_power_sequence_controller psc_seq_checker #(
    .SLOT_SHORT(SLOT_SHORT), .SLOT_LONG(SLOT_LONG)
) psc_seq_checker_inst (
    .sys_clk(sys_clk), .srst(srst), .rst_src(rst_src), .power_on_request(power_on_request),
    .reverse_poweroff_bit(reverse_poweroff_bit), .slot_duration_bit(slot_duration_bit),
    .sleep_in(sleep_in), .res_enable(res_enable), .boot_mode(boot_mode),
    .strap_pad_enable(strap_pad_enable), .pwr_state(pwr_state),
    .general_reset(general_reset), .turnoff_reset(turnoff_reset)
);

// [tb_top.sv]
/* self-checking bench for the power sequence controller.
   slots shortened to 5 and 20 cycles; host pins from psc_host_model. */
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    psc_pkg::psc_rst_s rs = 4'h8;
    logic req = 1'b0, rev = 1'b0, sdb = 1'b0, strap = 1'b0, flt = 1'b0;
    logic use_pin = 1'b0, want = 1'b0, irq = 1'b0, pinv = 1'b0;
    logic sel_wr = 1'b0;
    logic [1:0] tgt = 2'h0;
    logic [3:0] code = 4'h0;
    logic [18:0] lp_sel = 19'h00ff3;
    logic [18:0] en, lp;
    logic clko, sro, pad, gr, tr;
    psc_pkg::psc_sleep_s slp;
    psc_pkg::psc_boot_cfg_s cfg;
    psc_pkg::psc_boot_e bm;
    psc_pkg::psc_state_e st;
    int fails = 0;
    int num_checks = 0;

    psc_power_sequence_controller #(.SLOT_SHORT(5), .SLOT_LONG(20)) psc_power_sequence_controller_inst (
        .sys_clk(clk), .srst(srst), .rst_src(rs), .power_on_request(req),
        .reverse_poweroff_bit(rev), .slot_duration_bit(sdb), .sleep_in(slp),
        .sleep_lp_select(lp_sel), .boot_mode_strap(strap), .boot_strap_floating(flt),
        .eeprom_slots(76'h0), .eeprom_cfg(20'h0), .sel_wr(sel_wr), .sel_wr_target(tgt),
        .sel_wr_code(code), .res_enable(en), .res_low_power(lp), .low_freq_clock_output_en(clko),
        .system_reset_output(sro), .boot_cfg(cfg), .boot_mode(bm), .strap_pad_enable(pad),
        .pwr_state(st), .general_reset(gr), .turnoff_reset(tr));
    psc_host_model psc_host_model_inst (.sys_clk(clk), .use_pin(use_pin), .want_sleep(want),
        .irq(irq), .pol_inv(pinv), .sleep_in(slp));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    function automatic logic [18:0] upto(input int k);
        upto = '0;
        for (int r = 0; r < psc_pkg::NUM_RES; r++) begin
            if (psc_pkg::FIXED_SLOTS[r*4 +: 4] != 4'h0 && psc_pkg::FIXED_SLOTS[r*4 +: 4] <= k)
                upto[r] = 1'b1;
        end
    endfunction : upto

    task automatic t_boot(input logic s, input logic f, input psc_pkg::psc_boot_e m);
        strap <= s;
        flt <= f;
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check({bm, pad, tr, st}, {m, 1'b0, 1'b1, psc_pkg::PSC_ST_OFF});
        if (m == psc_pkg::PSC_BOOT_FIXED)
            check(cfg, {4'ha, 4'hf, 4'h0, 2'h1, 1'b0, 2'h0, 3'h7});
    endtask : t_boot

    task automatic t_on(input logic d);
        logic [18:0] m;
        @(posedge clk);
        sdb <= d;
        req <= 1'b1;
        repeat (4) @(posedge clk);
        for (int k = 1; k <= 16; k++) begin
            #1;
            m = upto(k);
            check({clko, sro, en}, {m[12], m[13], m});
            repeat (d ? 20 : 5) @(posedge clk);
        end
        check(st, psc_pkg::PSC_ST_ACTIVE);
    endtask : t_on

    task automatic t_off(input logic r);
        @(posedge clk);
        sdb <= 1'b0;
        rev <= r;
        req <= 1'b0;
        repeat (4) @(posedge clk);
        for (int j = 14; j >= 0; j--) begin
            #1;
            check(en, r ? upto(j) : 19'h0);
            repeat (5) @(posedge clk);
        end
        check(st, psc_pkg::PSC_ST_OFF);
    endtask : t_off

    task automatic t_sleep();
        // use_pin, want, pol_inv, irq, expect sleep
        logic [4:0] tb [6] = '{5'b01001, 5'b11101, 5'b00000, 5'b10000, 5'b01010, 5'b11110};
        foreach (tb[i]) begin
            @(posedge clk);
            {use_pin, want, pinv, irq} <= tb[i][4:1];
            repeat (4) @(posedge clk);
            #1;
            check(st == psc_pkg::PSC_ST_SLEEP, tb[i][0]);
            if (tb[i][0])
                check(lp, lp_sel & upto(15));
            @(posedge clk);
            irq <= 1'b1;
            repeat (4) @(posedge clk);
            #1;
            check(st, psc_pkg::PSC_ST_ACTIVE);
            @(posedge clk);
            {want, irq} <= 2'b00;
            repeat (3) @(posedge clk);
        end
    endtask : t_sleep

    task automatic t_sel(input logic [1:0] t, input logic [3:0] c, input logic [3:0] e);
        @(posedge clk);
        {sel_wr, tgt, code} <= {1'b1, t, c};
        @(posedge clk);
        sel_wr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check(t[1] ? cfg.ext_fet_code : cfg.core_a_code, e);
    endtask : t_sel

    task automatic t_resets();
        for (int i = 0; i < 4; i++) begin
            t_on(1'b0);
            @(posedge clk);
            rs[i] <= ~rs[i];
            repeat (3) @(posedge clk);
            #1;
            if (i == 3)
                check({st, en}, {psc_pkg::PSC_ST_STRAP, 19'h0});
            else
                check({gr, tr, bm, en}, {2'b11, psc_pkg::PSC_BOOT_FIXED, 19'h0});
            @(posedge clk);
            rs[i] <= ~rs[i];
            req <= 1'b0;
            repeat (3) @(posedge clk);
            #1;
            check(st, psc_pkg::PSC_ST_OFF);
        end
    endtask : t_resets

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #200000;
        fails++;
        finish_test();
    end

    initial begin
        t_boot(1'b1, 1'b0, psc_pkg::PSC_BOOT_EEPROM);
        t_boot(1'b0, 1'b1, psc_pkg::PSC_BOOT_TEST);
        t_boot(1'b0, 1'b0, psc_pkg::PSC_BOOT_FIXED);
        t_sel(2'h2, 4'h5, 4'h5);
        t_on(1'b1);
        t_off(1'b0);
        t_on(1'b0);
        t_sel(2'h0, 4'h2, psc_pkg::CORE_A_BOOT_CODE);
        t_sleep();
        t_off(1'b1);
        t_resets();
        finish_test();
    end
endmodule : tb_top
